// ==== src/ctlk_top.sv ====
`include "ctlk_defs.svh"

module ctlk_top (
  // system
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // control link
  input  wire logic                    link_clk,
  input  wire logic                    link_rx,
  output logic                         link_tx,
  output logic                         link_busy,
  // recovered clock
  output logic                         int_clk,
  output logic                         int_tick,
  // front end controls
  output logic [`CTLK_THR_MSB:0]       thr_code,
  output logic [`CTLK_DATA_W-1:0]      chan_mask,
  output logic                         gain_sel,
  output logic                         atten_en,
  output logic [7:0]                   qinj_level,
  output logic                         ts_reset,
  output logic                         qinj_fire
);
  import ctlk_pkg::*;

  function automatic logic [`CTLK_DATA_W-1:0] reg_read(
    input logic [`CTLK_ADDR_W-1:0] idx,
    input ctlk_regs_t              r,
    input logic [7:0]              st);
    logic [`CTLK_DATA_W-1:0] v;
    v = '0;
    if (idx == `CTLK_IDX_THRESH) v = {9'h000, r.thr};
    else if (idx == `CTLK_IDX_MASK) v = r.mask;
    else if (idx == `CTLK_IDX_QINJ) v = r.qinj;
    else if (idx == `CTLK_IDX_CONFIG) v = {13'h0000, r.cfg};
    else if (idx == `CTLK_IDX_STATUS) v = {8'h00, st};
    return v;
  endfunction

  function automatic logic idx_ok(input logic [`CTLK_ADDR_W-1:0] idx);
    return idx <= `CTLK_IDX_STATUS;
  endfunction

  // link pins cross from outside: two flops before any use
  logic [1:0] clk_sync;
  logic [1:0] rx_sync;
  logic       clk_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sync <= 2'h0;
      rx_sync  <= 2'h0;
      clk_d    <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], link_clk};
      rx_sync  <= {rx_sync[0], link_rx};
      clk_d    <= clk_sync[1];
    end
  end

  logic rise;
  logic fall;
  assign rise = clk_sync[1] & ~clk_d;
  assign fall = ~clk_sync[1] & clk_d;

  // recovered clock follows link clock, so duty stays that of the link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_clk  <= 1'b0;
      int_tick <= 1'b0;
    end else begin
      int_clk  <= clk_sync[1];
      int_tick <= rise;
    end
  end

  // manchester receive: first half at rise, inverse expected at fall
  logic first_half;
  logic bit_ev;
  logic bit_val;
  logic code_bad;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_half <= 1'b0;
    end else if (rise) begin
      first_half <= rx_sync[1];
    end
  end
  assign bit_ev   = fall;
  assign bit_val  = first_half;
  assign code_bad = fall & (rx_sync[1] == first_half);

  // receiver framing
  ctlk_rx_state_t          rx_state;
  logic [`CTLK_HDR_W-1:0]  hdr_sh;
  logic [`CTLK_BODY_BITS-1:0] body_sh;
  logic [4:0]              rx_cnt;
  logic                    frame_done;
  ctlk_frame_t             frame;
  logic                    code_err;
  logic [7:0]              frame_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state   <= CTLK_HUNT;
      hdr_sh     <= '0;
      body_sh    <= '0;
      rx_cnt     <= 5'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      case (rx_state)
        CTLK_HUNT: begin
          if (bit_ev) begin
            hdr_sh <= {hdr_sh[`CTLK_HDR_W-2:0], bit_val};
            if ({hdr_sh[`CTLK_HDR_W-2:0], bit_val} == `CTLK_HDR && !code_bad) begin
              rx_state <= CTLK_BODY;
              rx_cnt   <= 5'h00;
            end
          end
        end
        CTLK_BODY: begin
          if (code_bad) begin
            rx_state <= CTLK_HUNT;
            hdr_sh   <= '0;
          end else if (bit_ev) begin
            body_sh <= {body_sh[`CTLK_BODY_BITS-2:0], bit_val};
            rx_cnt  <= rx_cnt + 5'h01;
            if (rx_cnt == `CTLK_BODY_LAST) begin
              rx_state   <= CTLK_HUNT;
              hdr_sh     <= '0;
              frame_done <= 1'b1;
            end
          end
        end
        default: rx_state <= CTLK_HUNT;
      endcase
    end
  end
  assign frame = ctlk_frame_t'(body_sh);

  // timed commands: fixed tick pipeline from frame end
  logic [`CTLK_CMD_LAT-1:0] crst_pipe;
  logic [`CTLK_CMD_LAT-1:0] qfire_pipe;
  logic                     crst_req;
  logic                     qfire_req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crst_req   <= 1'b0;
      qfire_req  <= 1'b0;
      crst_pipe  <= '0;
      qfire_pipe <= '0;
      ts_reset   <= 1'b0;
      qinj_fire  <= 1'b0;
    end else begin
      ts_reset  <= 1'b0;
      qinj_fire <= 1'b0;
      if (frame_done && frame.op == `CTLK_OP_CRST) crst_req <= 1'b1;
      if (frame_done && frame.op == `CTLK_OP_QFIRE) qfire_req <= 1'b1;
      if (rise) begin
        crst_pipe  <= {crst_pipe[`CTLK_CMD_LAT-2:0], crst_req};
        qfire_pipe <= {qfire_pipe[`CTLK_CMD_LAT-2:0], qfire_req};
        crst_req   <= 1'b0;
        qfire_req  <= 1'b0;
        ts_reset   <= crst_pipe[`CTLK_CMD_LAT-1];
        qinj_fire  <= qfire_pipe[`CTLK_CMD_LAT-1];
      end
    end
  end

  // axi write channel: address and data taken in either order
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        aw_got;
  logic        w_got;
  logic        axi_wr;
  assign axi_wr = aw_got & w_got & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CTLK_RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
    end else begin
      s_axi_awready <= ~aw_got & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_got & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (axi_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (idx_ok(aw_addr[7:2]) && aw_addr[7:2] != `CTLK_IDX_STATUS)
                        ? `CTLK_RESP_OKAY : `CTLK_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end
    end
  end

  // register file, shared by link and bus; a link write wins a clash
  ctlk_regs_t regs;
  logic       lnk_wr;
  logic [`CTLK_ADDR_W-1:0] wr_idx;
  logic [`CTLK_DATA_W-1:0] wr_dat;
  logic [1:0]              wr_be;
  assign lnk_wr = frame_done & (frame.op == `CTLK_OP_WRITE);
  assign wr_idx = lnk_wr ? frame.addr : aw_addr[7:2];
  assign wr_dat = lnk_wr ? frame.data : w_data[15:0];
  assign wr_be  = lnk_wr ? 2'h3 : s_axi_wstrb[1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs.thr  <= `CTLK_THR_RST;
      regs.mask <= `CTLK_MASK_RST;
      regs.qinj <= `CTLK_QINJ_RST;
      regs.cfg  <= `CTLK_CFG_RST;
    end else if (lnk_wr || axi_wr) begin
      if (wr_idx == `CTLK_IDX_THRESH) begin
        if (wr_be[0]) regs.thr <= wr_dat[`CTLK_THR_MSB:0];
      end else if (wr_idx == `CTLK_IDX_MASK) begin
        if (wr_be[0]) regs.mask[7:0] <= wr_dat[7:0];
        if (wr_be[1]) regs.mask[15:8] <= wr_dat[15:8];
      end else if (wr_idx == `CTLK_IDX_QINJ) begin
        if (wr_be[0]) regs.qinj[7:0] <= wr_dat[7:0];
        if (wr_be[1]) regs.qinj[15:8] <= wr_dat[15:8];
      end else if (wr_idx == `CTLK_IDX_CONFIG) begin
        if (wr_be[0]) regs.cfg <= wr_dat[2:0];
      end
    end
  end

  // status: code error sticky, set wins over clear by status write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_err  <= 1'b0;
      frame_cnt <= 8'h00;
    end else begin
      if (code_bad && rx_state == CTLK_BODY) code_err <= 1'b1;
      else if ((lnk_wr || axi_wr) && wr_idx == `CTLK_IDX_STATUS) code_err <= 1'b0;
      if (frame_done) frame_cnt <= frame_cnt + 8'h01;
    end
  end

  logic [7:0] status;
  assign status = {frame_cnt[5:0], link_busy, code_err};

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CTLK_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, reg_read(s_axi_araddr[7:2], regs, status)};
        s_axi_rresp  <= idx_ok(s_axi_araddr[7:2]) ? `CTLK_RESP_OKAY
                                                  : `CTLK_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // link transmit: read reply framed like a request, bits paced by link
  logic [`CTLK_FRAME_BITS-1:0] tx_sh;
  logic [4:0]                  tx_cnt;
  logic                        tx_bit;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh     <= '0;
      tx_cnt    <= 5'h00;
      tx_bit    <= 1'b0;
      link_busy <= 1'b0;
      link_tx   <= 1'b0;
    end else begin
      if (frame_done && frame.op == `CTLK_OP_READ && !link_busy) begin
        link_busy <= 1'b1;
        tx_sh     <= {`CTLK_HDR, frame.op, frame.addr,
                      reg_read(frame.addr, regs, status)};
        tx_cnt    <= 5'h00;
      end else if (rise && link_busy) begin
        tx_bit  <= tx_sh[`CTLK_FRAME_BITS-1];
        link_tx <= tx_sh[`CTLK_FRAME_BITS-1];
        tx_sh   <= {tx_sh[`CTLK_FRAME_BITS-2:0], 1'b0};
        // wraps to zero after the last bit of the frame
        tx_cnt  <= tx_cnt + 5'h01;
      end else if (fall && link_busy) begin
        link_tx <= ~tx_bit;
        // busy dropped at the fall that starts the low half of the last bit
        if (tx_cnt == 5'h00) link_busy <= 1'b0;
      end else if (fall) begin
        link_tx <= 1'b0;
      end
    end
  end

  // front end drive; threshold never scaled by gain or attenuator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_code   <= `CTLK_THR_RST;
      chan_mask  <= `CTLK_MASK_RST;
      gain_sel   <= 1'b0;
      atten_en   <= 1'b0;
      qinj_level <= 8'h00;
    end else begin
      thr_code  <= regs.thr;
      chan_mask <= regs.mask;
      gain_sel  <= regs.cfg[`CTLK_CFG_GAIN];
      atten_en  <= regs.cfg[`CTLK_CFG_ATTEN];
      if (regs.cfg[`CTLK_CFG_QPROG])
        qinj_level <= regs.qinj[`CTLK_QINJ_LO_MSB:0];
      else if (regs.cfg[`CTLK_CFG_GAIN])
        qinj_level <= regs.qinj[15:`CTLK_QINJ_HI_LSB];
      else
        qinj_level <= regs.qinj[`CTLK_QINJ_LO_MSB:0];
    end
  end

  a_tick_on_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    rise |=> int_tick && int_clk)
    else $error("tick missing after link clock rise");

  a_clk_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    fall |=> !int_clk)
    else $error("recovered clock not low after fall");

  a_hdr_realign: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_state == CTLK_HUNT ##1 rx_state == CTLK_BODY |-> rx_cnt == 5'h00)
    else $error("bit counter not realigned on header");

  a_frame_len: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_done |-> $past(rx_cnt) == `CTLK_BODY_LAST)
    else $error("frame ended at wrong bit count");

  a_crst_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    rise && crst_pipe[`CTLK_CMD_LAT-1] |=> ts_reset)
    else $error("counter reset not issued at fixed latency");

  a_qfire_lat: assert property (@(posedge aclk) disable iff (!aresetn)
    qinj_fire |-> $past(qfire_pipe[`CTLK_CMD_LAT-1]) && $past(rise))
    else $error("charge fire without queued command");

  a_thr_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 thr_code == $past(regs.thr))
    else $error("threshold code altered by gain state");

  a_qinj_gain: assert property (@(posedge aclk) disable iff (!aresetn)
    !regs.cfg[`CTLK_CFG_QPROG] && regs.cfg[`CTLK_CFG_GAIN]
      |=> qinj_level == $past(regs.qinj[15:8]))
    else $error("injected amount does not follow gain");

  a_link_write: assert property (@(posedge aclk) disable iff (!aresetn)
    lnk_wr && frame.addr == `CTLK_IDX_MASK |=> regs.mask == $past(frame.data))
    else $error("link write did not reach register");

  a_busy_read: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_done && frame.op == `CTLK_OP_READ && !link_busy |=> link_busy)
    else $error("read reply did not start");

endmodule // ctlk_top

// ==== src/ctlk_defs.svh ====
`ifndef CTLK_DEFS_SVH
`define CTLK_DEFS_SVH

// link frame layout: header, then op, address and data, fixed length
`define CTLK_HDR_W        8
`define CTLK_HDR          8'hB4
`define CTLK_OP_W         2
`define CTLK_ADDR_W       6
`define CTLK_DATA_W       16
`define CTLK_BODY_BITS    24
`define CTLK_FRAME_BITS   32
`define CTLK_BODY_LAST    5'h17
`define CTLK_FRAME_LAST   5'h1F

// link opcodes
`define CTLK_OP_WRITE     2'h0
`define CTLK_OP_READ      2'h1
`define CTLK_OP_CRST      2'h2
`define CTLK_OP_QFIRE     2'h3

// command pipeline depth, in internal clock ticks; the pulse comes on the fourth tick after the last bit
`define CTLK_CMD_LAT      3

// register indices; byte address on the bus is four times the index
`define CTLK_IDX_THRESH   6'h00
`define CTLK_IDX_MASK     6'h01
`define CTLK_IDX_QINJ     6'h02
`define CTLK_IDX_CONFIG   6'h03
`define CTLK_IDX_STATUS   6'h04

// field positions
`define CTLK_THR_MSB      6
`define CTLK_QINJ_LO_MSB  7
`define CTLK_QINJ_HI_LSB  8
`define CTLK_CFG_GAIN     0
`define CTLK_CFG_ATTEN    1
`define CTLK_CFG_QPROG    2
`define CTLK_ST_CODEERR   0
`define CTLK_ST_TXBUSY    1
`define CTLK_ST_FCNT_LSB  8

// reset values
`define CTLK_THR_RST      7'h10
`define CTLK_MASK_RST     16'hFFFF
`define CTLK_QINJ_RST     16'h8020
`define CTLK_CFG_RST      3'h0

// bus answers
`define CTLK_RESP_OKAY    2'h0
`define CTLK_RESP_SLVERR  2'h2

`endif

// ==== src/ctlk_pkg.sv ====
`include "ctlk_defs.svh"

package ctlk_pkg;

  typedef enum logic [1:0] {
    CTLK_WRITE,
    CTLK_READ,
    CTLK_CRST,
    CTLK_QFIRE
  } ctlk_op_t;

  typedef enum logic {
    CTLK_HUNT,
    CTLK_BODY
  } ctlk_rx_state_t;

  typedef struct packed {
    logic [`CTLK_OP_W-1:0]   op;
    logic [`CTLK_ADDR_W-1:0] addr;
    logic [`CTLK_DATA_W-1:0] data;
  } ctlk_frame_t;

  typedef struct packed {
    logic [`CTLK_THR_MSB:0]  thr;
    logic [`CTLK_DATA_W-1:0] mask;
    logic [`CTLK_DATA_W-1:0] qinj;
    logic [2:0]              cfg;
  } ctlk_regs_t;

endpackage : ctlk_pkg

// ==== bench/ctlk_ctrl_model.sv ====
// off-chip controller: makes the link clock, sends frames, reads replies
module ctlk_ctrl_model (
  // link pins
  output logic      link_clk,
  output logic      link_rx,
  input  wire logic link_tx
);
  timeunit 1ns;
  timeprecision 1ns;

  logic cur;
  logic bad;

  // runs free: the chip's own clock is recovered from it
  initial begin
    link_clk = 1'b0;
    cur      = 1'b0;
    bad      = 1'b0;
    #137;
    forever #400 link_clk = ~link_clk;
  end

  // bit in high half, inverse in low half; bad breaks the low half
  assign link_rx = link_clk ? cur : (~cur ^ bad);

  // one bit per link period, msb first, as many bits as the bench asks
  task automatic send_bits(input logic [31:0] v, input int n,
                           input int bad_at);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge link_clk);
      cur = v[i];
      bad = (i == bad_at);
    end
    @(posedge link_clk);
    cur = 1'b0;
    bad = 1'b0;
  endtask

  // reply starts with a one, the line idles low
  task automatic get_reply(output logic [31:0] v, output logic ok);
    v = 32'h0;
    for (int n = 0; n < 4000 && link_tx !== 1'b1; n++) #10;
    ok = (link_tx === 1'b1);
    #200;
    for (int i = 31; i >= 0; i--) begin
      v[i] = link_tx;
      #400;
      if (link_tx === v[i]) ok = 1'b0;
      #400;
    end
  endtask
endmodule // ctlk_ctrl_model

// ==== bench/testbench.sv ====
`include "ctlk_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, qinj_level;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        link_clk, link_rx, link_tx, link_busy, int_clk, int_tick;
  logic [6:0]  thr_code;
  logic [15:0] chan_mask;
  logic        gain_sel, atten_en, ts_reset, qinj_fire;
  int          err_count, cmp_count;

  ctlk_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_clk(link_clk), .link_rx(link_rx), .link_tx(link_tx),
    .link_busy(link_busy), .int_clk(int_clk), .int_tick(int_tick),
    .thr_code(thr_code), .chan_mask(chan_mask), .gain_sel(gain_sel),
    .atten_en(atten_en), .qinj_level(qinj_level), .ts_reset(ts_reset),
    .qinj_fire(qinj_fire)
  );

  ctlk_ctrl_model ctl (
    .link_clk(link_clk), .link_rx(link_rx), .link_tx(link_tx)
  );

  always #50 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        chk("bresp", bresp, er);
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    // output copies trail the registers by a cycle
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er, input logic [31:0] m = 32'hFFFFFFFF);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        chk("rdata", rdata & m, e);
        chk("rresp", rresp, er);
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic t_reset;
    chk("thr_rst", thr_code, `CTLK_THR_RST);
    chk("mask_rst", chan_mask, `CTLK_MASK_RST);
    chk("busy_rst", link_busy, 1'b0);
    rd(8'h00, `CTLK_THR_RST, `CTLK_RESP_OKAY);
    rd(8'h04, `CTLK_MASK_RST, `CTLK_RESP_OKAY);
    rd(8'h08, `CTLK_QINJ_RST, `CTLK_RESP_OKAY);
    rd(8'h0C, `CTLK_CFG_RST, `CTLK_RESP_OKAY);
    rd(8'h14, 32'h0, `CTLK_RESP_SLVERR);
    chk("qlvl_rst", qinj_level, 8'h20);
  endtask

  task automatic t_clk;
    int hi;
    int tk;
    hi = 0;
    tk = 0;
    repeat (80) begin
      @(posedge aclk);
      if (int_clk === 1'b1) hi++;
      if (int_tick === 1'b1) tk++;
    end
    chk("clk_high", hi, 40);
    chk("ticks", tk, 10);
  endtask

  task automatic t_regs;
    wr(8'h00, 32'hFF, 4'hF, `CTLK_RESP_OKAY);
    chk("thr7", thr_code, 7'h7F);
    wr(8'h04, 32'h1234, 4'h1, `CTLK_RESP_OKAY);
    rd(8'h04, 32'hFF34, `CTLK_RESP_OKAY);
    chk("mask_out", chan_mask, 16'hFF34);
    wr(8'h08, 32'h9A55, 4'hF, `CTLK_RESP_OKAY);
    wr(8'h0C, 32'h1, 4'hF, `CTLK_RESP_OKAY);
    chk("gain", gain_sel, 1'b1);
    chk("q_high", qinj_level, 8'h9A);
    chk("thr_gain", thr_code, 7'h7F);
    wr(8'h0C, 32'h7, 4'hF, `CTLK_RESP_OKAY);
    chk("atten", atten_en, 1'b1);
    chk("q_prog", qinj_level, 8'h55);
    chk("thr_att", thr_code, 7'h7F);
    wr(8'h18, 32'h1, 4'hF, `CTLK_RESP_SLVERR);
  endtask

  task automatic t_link_wr;
    // stray bits first: the receiver must find the header itself
    ctl.send_bits(32'h6, 3, -1);
    ctl.send_bits({`CTLK_HDR, `CTLK_OP_WRITE, `CTLK_IDX_THRESH, 16'h0005},
                  32, -1);
    repeat (10) @(posedge aclk);
    chk("thr_link", thr_code, 7'h05);
    rd(8'h00, 32'h05, `CTLK_RESP_OKAY);
  endtask

  task automatic t_link_rd;
    logic [31:0] v;
    logic        ok;
    ctl.send_bits({`CTLK_HDR, `CTLK_OP_READ, `CTLK_IDX_MASK, 16'h0},
                  32, -1);
    fork
      ctl.get_reply(v, ok);
      begin
        #4000;
        chk("busy_on", link_busy, 1'b1);
      end
    join
    chk("reply", v, {`CTLK_HDR, `CTLK_OP_READ, `CTLK_IDX_MASK,
        16'hFF34});
    chk("tx_code", ok, 1'b1);
    #2000;
    chk("busy_off", link_busy, 1'b0);
  endtask

  task automatic t_err;
    // broken low half inside the data field: frame must be dropped
    ctl.send_bits({`CTLK_HDR, `CTLK_OP_WRITE, `CTLK_IDX_THRESH, 16'h0033},
                  32, 10);
    repeat (10) @(posedge aclk);
    chk("thr_kept", thr_code, 7'h05);
    rd(8'h10, 32'h1, `CTLK_RESP_OKAY, 32'h1);
    wr(8'h10, 32'h0, 4'hF, `CTLK_RESP_SLVERR);
    rd(8'h10, 32'h0, `CTLK_RESP_OKAY, 32'h1);
  endtask

  task automatic t_cmd;
    int          lat[3];
    logic [1:0]  op;
    int          n;
    for (int k = 0; k < 3; k++) begin
      op = (k < 2) ? `CTLK_OP_CRST : `CTLK_OP_QFIRE;
      ctl.send_bits({`CTLK_HDR, op, 6'h00, 16'h0}, 32, -1);
      n = 0;
      while (n < 300 && ((k < 2) ? ts_reset : qinj_fire) !== 1'b1) begin
        @(posedge aclk);
        n++;
      end
      lat[k] = n;
      @(posedge aclk);
      chk("pulse_w", (k < 2) ? ts_reset : qinj_fire, 1'b0);
    end
    chk("lat_seen", lat[0] < 300, 1'b1);
    chk("lat_rst", lat[1], lat[0]);
    chk("lat_fire", lat[2], lat[0]);
  endtask

  initial begin
    aclk      = 1'b0;
    aresetn   = 1'b0;
    awaddr    = 8'h0;
    awvalid   = 1'b0;
    wdata     = 32'h0;
    wstrb     = 4'h0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    araddr    = 8'h0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_clk;
    t_regs;
    t_link_wr;
    t_link_rd;
    t_err;
    t_cmd;
    results;
  end

  // the whole sequence needs well under half of this
  initial begin
    #3000000;
    err_count++;
    results;
  end
endmodule // testbench
